//--- core/csq_ctrl.sv
// Charger source selection and qualification control.
// Assumes comparator levels arrive unsynchronised and host control bits
// come from the serial interface logic on the same clock.
//
// Contract
// RULE_01: Power-fail low on battery UV, overtemp warning, cover removed.
// RULE_02: Alert low on charge fault, termination or regulator low.
// RULE_03: Charge when adapter or USB above lockout, no host needed.
// RULE_04: Prefer adapter; choose USB only when adapter is absent; code also chooses USB when the adapter is present but in overvoltage.
// RULE_05: With both inputs valid, adapter wins.
// RULE_06: USB current limit low after reset; host may raise it.
// RULE_07: Host controls disable the whole charger or only USB.
// RULE_08: USB charging starts only after a host veto delay.
// RULE_09: Adapter overvoltage disables charging; code drops only the adapter and still charges from USB when USB is valid.
// RULE_10: Charge only while thermistor voltage is inside the window.
// RULE_11: Out-of-window temperature stops the FET, freezes timers.
// RULE_12: Back in window, charging resumes with timers continuing.
// RULE_13: Inputs synchronised; source re-evaluated every cycle.
`timescale 1ns/1ps
module csq_ctrl
    import csq_pkg::*;
#(
    parameter int unsigned USB_DELAY = csq_pkg::USB_DELAY_CYC
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // Analog comparators (asynchronous)
    input  wire logic              ac_ok_i,
    input  wire logic              usb_ok_i,
    input  wire logic              ac_ov_i,
    input  wire logic              cold_threshold_i,
    input  wire logic              hot_threshold_i,
    input  wire logic              bat_uv_i,
    input  wire logic              ot_warn_i,
    input  wire logic              battery_cover_present_i,
    input  wire logic              reg_low_i,
    // Charge state events from charger core (same clock)
    input  wire logic              chg_fault_i,
    input  wire logic              chg_done_i,
    // Host controls (same clock)
    input  wire csq_pkg::csq_ctrl_s host_ctrl_i,
    // Outputs
    output csq_pkg::csq_chg_s       chg_o,
    output logic                   power_fail_warn_n_o,
    output logic                   alert_n_o
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] syn;

    assign raw[B_AC_OK]   = ac_ok_i;
    assign raw[B_USB_OK]  = usb_ok_i;
    assign raw[B_AC_OV]   = ac_ov_i;
    assign raw[B_COLD]    = cold_threshold_i;
    assign raw[B_HOT]     = hot_threshold_i;
    assign raw[B_BAT_UV]  = bat_uv_i;
    assign raw[B_OT_WARN] = ot_warn_i;
    assign raw[B_COVER]   = battery_cover_present_i;
    assign raw[B_REG_LOW] = reg_low_i;

    csq_sync #(
        .W       (SYNC_W)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i (raw),
        .sync_o  (syn)                                      // RULE_13
    );

    // ------------------------------------------------------------------
    // Qualification and source choice
    // ------------------------------------------------------------------
    // Adapter above overvoltage is treated as unusable, not merely off
    wire ac_valid   = syn[B_AC_OK] & ~syn[B_AC_OV];          // RULE_09
    wire usb_valid  = syn[B_USB_OK] & ~host_ctrl_i.usb_disable; // RULE_07
    wire temp_ok    = ~syn[B_COLD] & ~syn[B_HOT];            // RULE_10
    wire chg_enable = ~host_ctrl_i.chg_disable;              // RULE_07

    // Re-evaluated every cycle so a returning adapter takes over
    wire pick_ac  = ac_valid;                                // RULE_04 RULE_05
    wire pick_usb = ~ac_valid & usb_valid;                   // RULE_04 RULE_13
    csq_src_e src_d;
    assign src_d = !chg_enable ? CSQ_SRC_NONE :
                   pick_ac     ? CSQ_SRC_AC   :
                   pick_usb    ? CSQ_SRC_USB  : CSQ_SRC_NONE; // RULE_03

    // ------------------------------------------------------------------
    // USB start delay: counts only while USB is the candidate source
    // ------------------------------------------------------------------
    logic [USB_CNT_W-1:0] usb_cnt_q;
    logic [USB_CNT_W-1:0] usb_cnt_d;
    wire  usb_ready = (usb_cnt_q == USB_CNT_W'(USB_DELAY));

    // Restart the delay whenever USB stops being chosen, so a host
    // veto issued during the window always lands before the FET
    assign usb_cnt_d = (src_d != CSQ_SRC_USB) ? '0 :
                       usb_ready ? usb_cnt_q :
                       usb_cnt_q + USB_CNT_W'(1);            // RULE_08

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            usb_cnt_q <= '0;
        end else begin
            usb_cnt_q <= usb_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Charge control outputs
    // ------------------------------------------------------------------
    wire src_live = (src_d == CSQ_SRC_AC) |
                    ((src_d == CSQ_SRC_USB) & usb_ready);
    // Timers hold (not clear) while temperature is out of window
    wire run_d    = src_live & temp_ok;                      // RULE_11 RULE_12

    csq_chg_s chg_d;
    assign chg_d.fet_on       = run_d;                       // RULE_11
    assign chg_d.timer_run    = run_d;                       // RULE_12
    assign chg_d.usb_high_cur = host_ctrl_i.usb_high;        // RULE_06
    assign chg_d.source       = src_d;

    // Status pins, active low
    wire pf_n_d    = ~(syn[B_BAT_UV] | syn[B_OT_WARN] |
                       ~syn[B_COVER]);                       // RULE_01
    wire alert_n_d = ~(chg_fault_i | chg_done_i |
                       syn[B_REG_LOW]);                      // RULE_02

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chg_o               <= '{1'b0, 1'b0, USB_HI_RST,
                                     CSQ_SRC_NONE};          // RULE_06
            power_fail_warn_n_o <= 1'b1;
            alert_n_o           <= 1'b1;
        end else begin
            chg_o               <= chg_d;
            power_fail_warn_n_o <= pf_n_d;
            alert_n_o           <= alert_n_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_ac_in;
        syn[B_AC_OK] && !syn[B_AC_OV] && !host_ctrl_i.chg_disable;
    endsequence

    // Adapter valid and charger enabled: adapter must be the source
    a_ac_priority: assert property ( // RULE_05
        s_ac_in |=> chg_o.source == CSQ_SRC_AC)
        else $error("adapter not chosen when valid");
    // USB may only be chosen when the adapter was not usable
    a_usb_only: assert property ( // RULE_04
        chg_o.source == CSQ_SRC_USB |-> !$past(ac_valid))
        else $error("usb chosen with adapter valid");
    // Overvoltage with no USB fallback leaves the FET off
    a_ov_block: assert property ( // RULE_09
        syn[B_AC_OV] && !usb_valid |=> !chg_o.fet_on)
        else $error("charging with adapter overvoltage");
    // Power on USB only once the veto delay has fully run
    a_usb_wait: assert property ( // RULE_08
        chg_o.fet_on && chg_o.source == CSQ_SRC_USB |->
        $past(usb_ready))
        else $error("usb fet on before delay ran out");
    // Overtemperature warning and cover removal each pull power-fail
    a_pf_otw: assert property ( // RULE_01
        syn[B_OT_WARN] || !syn[B_COVER] |=> !power_fail_warn_n_o)
        else $error("power fail not asserted on warning or cover");
    // Regulator low pulls alert on its own
    a_alert_reg: assert property ( // RULE_02
        syn[B_REG_LOW] |=> !alert_n_o)
        else $error("alert not asserted on regulator low");
    // Both status pins return high once every cause is gone
    a_pins_idle: assert property ( // RULE_01 RULE_02
        !syn[B_BAT_UV] && !syn[B_OT_WARN] && syn[B_COVER] &&
        !chg_fault_i && !chg_done_i && !syn[B_REG_LOW] |=>
        power_fail_warn_n_o && alert_n_o)
        else $error("status pins stuck low");
    a_temp_win: assert property (!temp_ok |=> !chg_o.fet_on) // RULE_10
        else $error("fet on outside temperature window");
    a_timer_hold: assert property (chg_o.fet_on && !temp_ok |=> // RULE_11
        !chg_o.timer_run) else $error("timers not frozen");
    a_resume_ok: assert property (s_ac_in ##0 temp_ok |=> // RULE_12
        chg_o.fet_on) else $error("no resume in window");
    a_chg_off: assert property (host_ctrl_i.chg_disable |=> // RULE_07
        chg_o.source == CSQ_SRC_NONE) else $error("charger not disabled");
    a_usb_delay: assert property ($rose(chg_o.source == CSQ_SRC_USB) // RULE_08
        |-> !chg_o.fet_on) else $error("usb charging without delay");
    a_pf_pin: assert property (syn[B_BAT_UV] |=> !power_fail_warn_n_o) // RULE_01
        else $error("power fail not asserted");
    a_alert_pin: assert property (chg_fault_i || chg_done_i |=> // RULE_02
        !alert_n_o) else $error("alert not asserted");
    a_cur_limit: assert property (chg_o.usb_high_cur == // RULE_06
        $past(host_ctrl_i.usb_high)) else $error("usb limit mismatch");

endmodule

//--- core/csq_sync.sv
// Two-flop synchroniser bank for the comparator inputs.
// Assumes asynchronous inputs; first stage feeds only the second.
`timescale 1ns/1ps
module csq_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // ------------------------------------------------------------------
    // Synchroniser, one per bit
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q[g] <= 1'b0;
                    sync_o[g] <= 1'b0;
                end else begin
                    meta_q[g] <= async_i[g];
                    sync_o[g] <= meta_q[g];
                end
            end
        end
    endgenerate

endmodule

//--- dv/csq_host_model.sv
// Host processor model that programs the charger control bits.
// Assumes the bench hands it a requested control word on the falling edge.
`timescale 1ns/1ps
module csq_host_model
    import csq_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    // Requested control word
    input  wire csq_pkg::csq_ctrl_s req_i,
    // Control bits towards the charger
    output csq_pkg::csq_ctrl_s      host_ctrl_o
);
    // ------------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------------
    csq_ctrl_s pend_q;

    // Sampled on the rising edge so the request is stable when taken
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= '{CHG_DIS_RST, USB_DIS_RST, USB_HI_RST};
        end else begin
            pend_q <= req_i;
        end
    end

    // Driven half a cycle later, like a serial write landing off-edge
    always_ff @(negedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_ctrl_o <= '{CHG_DIS_RST, USB_DIS_RST, USB_HI_RST};
        end else begin
            host_ctrl_o <= pend_q;
        end
    end
endmodule

//--- dv/tb.sv
// Self-checking bench for the charger source qualification control.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    err_count++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb;
    import csq_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int DLY = 8;
    logic      mclk_i, rst_n_i, ac, usb, ov, cold, hot, uv, otw, cov, rlow;
    logic      fault, done, pf_n, al_n;
    csq_ctrl_s req;
    csq_ctrl_s hc;
    csq_chg_s  chg;
    int        err_count, cmp_count;

    csq_ctrl #(.USB_DELAY(DLY)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .ac_ok_i(ac), .usb_ok_i(usb), .ac_ov_i(ov), .cold_threshold_i(cold),
        .hot_threshold_i(hot), .bat_uv_i(uv), .ot_warn_i(otw),
        .battery_cover_present_i(cov), .reg_low_i(rlow), .chg_fault_i(fault),
        .chg_done_i(done), .host_ctrl_i(hc), .chg_o(chg),
        .power_fail_warn_n_o(pf_n), .alert_n_o(al_n));
    csq_host_model host_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req),
        .host_ctrl_o(hc));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Inputs change on the falling edge, away from the sampling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic idle();
        {ac, usb, ov, cold, hot, uv, otw, rlow, fault, done} = '0;
        cov = 1'b1;
        req = '0;
        cyc(5);
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK("chg_o", 5'h00, chg)
        `CHK("pf_n", 1'b1, pf_n)
        `CHK("al_n", 1'b1, al_n)
    endtask
    // USB alone waits out the veto delay; adapter then takes over
    task automatic t_usb();
        usb = 1'b1;
        cyc(4);
        `CHK("usb src", CSQ_SRC_USB, chg.source)
        `CHK("usb fet early", 1'b0, chg.fet_on)
        cyc(DLY + 3);
        `CHK("usb fet", 1'b1, chg.fet_on)
        `CHK("usb lo cur", 1'b0, chg.usb_high_cur)
        req.usb_high = 1'b1;
        cyc(4);
        `CHK("usb hi cur", 1'b1, chg.usb_high_cur)
        ac = 1'b1;
        cyc(4);
        `CHK("both src", CSQ_SRC_AC, chg.source)
        `CHK("both fet", 1'b1, chg.fet_on)
        idle();
    endtask
    // Adapter charging, overvoltage and temperature suspension
    task automatic t_ac_temp(input logic use_cold);
        ac = 1'b1;
        cyc(4);
        `CHK("ac fet", 1'b1, chg.fet_on)
        cold = use_cold;
        hot = !use_cold;
        cyc(4);
        `CHK("temp fet", 1'b0, chg.fet_on)
        `CHK("temp tmr", 1'b0, chg.timer_run)
        `CHK("temp src", CSQ_SRC_AC, chg.source)
        {cold, hot} = 2'b00;
        cyc(4);
        `CHK("resume tmr", 1'b1, chg.timer_run)
        ov = 1'b1;
        cyc(4);
        `CHK("ov fet", 1'b0, chg.fet_on)
        idle();
    endtask
    // Whole-charger and USB-only disables from the host
    task automatic t_disable();
        ac = 1'b1;
        req.chg_disable = 1'b1;
        cyc(5);
        `CHK("dis src", CSQ_SRC_NONE, chg.source)
        `CHK("dis fet", 1'b0, chg.fet_on)
        {ac, usb} = 2'b01;
        req = '{1'b0, 1'b1, 1'b0};
        cyc(DLY + 8);
        `CHK("usb dis fet", 1'b0, chg.fet_on)
        idle();
    endtask
    // Each cause pulls its warning output low on its own
    task automatic t_warn();
        for (int i = 0; i < 3; i++) begin
            {uv, otw, cov} = {i == 0, i == 1, i != 2};
            {fault, done, rlow} = {i == 0, i == 1, i == 2};
            cyc(4);
            `CHK("pf_n", 1'b0, pf_n)
            `CHK("al_n", 1'b0, al_n)
            idle();
            `CHK("pf_n idle", 1'b1, pf_n)
            `CHK("al_n idle", 1'b1, al_n)
        end
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    // Whole run needs about 140 cycles; this bound leaves margin
    initial begin
        repeat (3000) @(posedge mclk_i);
        err_count++;
        tally_and_finish();
    end
    initial begin
        err_count = 0;
        cmp_count = 0;
        rst_n_i = 1'b0;
        {ac, usb, ov, cold, hot, uv, otw, rlow, fault, done} = '0;
        cov = 1'b1;
        req = '0;
        cyc(10);
        t_reset();
        rst_n_i = 1'b1;
        cyc(5);
        t_usb();
        t_ac_temp(1'b1);
        t_ac_temp(1'b0);
        t_disable();
        t_warn();
        tally_and_finish();
    end
endmodule

//--- inc/csq_pkg.sv
// Package for the charger source qualification control block.
// Assumes a single 50 MHz clock and comparator inputs from the analog side.
package csq_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 20;
    // Delay before USB charging starts, in microseconds
    localparam int unsigned USB_DELAY_US   = 100000;
    localparam int unsigned USB_DELAY_CYC  =
        (USB_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned USB_CNT_W      = 24;
    localparam int unsigned SYNC_W         = 9;

    // ------------------------------------------------------------------
    // Current limits and reset values
    // ------------------------------------------------------------------
    localparam int unsigned USB_ILIM_LOW_MA  = 100;
    localparam int unsigned USB_ILIM_HIGH_MA = 500;
    localparam logic        USB_HI_RST       = 1'b0;
    localparam logic        CHG_DIS_RST      = 1'b0;
    localparam logic        USB_DIS_RST      = 1'b0;

    // Comparator bit positions in the raw input vector
    localparam int unsigned B_AC_OK   = 0;
    localparam int unsigned B_USB_OK  = 1;
    localparam int unsigned B_AC_OV   = 2;
    localparam int unsigned B_COLD    = 3;
    localparam int unsigned B_HOT     = 4;
    localparam int unsigned B_BAT_UV  = 5;
    localparam int unsigned B_OT_WARN = 6;
    localparam int unsigned B_COVER   = 7;
    localparam int unsigned B_REG_LOW = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CSQ_SRC_NONE,
        CSQ_SRC_AC,
        CSQ_SRC_USB
    } csq_src_e;

    typedef struct packed {
        logic chg_disable;
        logic usb_disable;
        logic usb_high;
    } csq_ctrl_s;

    typedef struct packed {
        logic     fet_on;
        logic     timer_run;
        logic     usb_high_cur;
        csq_src_e source;
    } csq_chg_s;

endpackage
